/* sids_regs.svh */
// Register offsets, field positions and reset values of the descriptor block
`ifndef SIDS_REGS_SVH
`define SIDS_REGS_SVH

// ************************************************************
// Register byte offsets (low address byte)
// ************************************************************
`define SIDS_OFF_STATE 8'h00
`define SIDS_OFF_PAGE0 8'h04
`define SIDS_OFF_PAGE1 8'h08
`define SIDS_OFF_MASKS 8'h0c

// ************************************************************
// Transfer-state word fields
// ************************************************************
`define SIDS_B_IOC 31
`define SIDS_B_PSEL 30
`define SIDS_TOTAL_MSB 25
`define SIDS_TOTAL_LSB 16
`define SIDS_PROG_MSB 15
`define SIDS_PROG_LSB 8
`define SIDS_B_ACTIVE 7
`define SIDS_B_RESP_ERR 6
`define SIDS_B_BUF_ERR 5
`define SIDS_B_BABBLE 4
`define SIDS_B_XACT_ERR 3
`define SIDS_B_MISSED 2
`define SIDS_B_PHASE 1

// Reserved bits 29..26 and 0 read as zero
`define SIDS_STATE_WMASK 32'hc3ff_fffe
`define SIDS_MASKS_WMASK 32'h0000_ffff
`define SIDS_RST_WORD 32'h0000_0000
`define SIDS_RST_MASKS 16'h0000

`endif

/* sids_pkg.sv */
// Types shared by the split isochronous descriptor state block
package sids_pkg;

    typedef struct packed {
        logic [31:0] state;
        logic [31:0] page0;
        logic [31:0] page1;
        logic [15:0] masks;
        logic irq_pend;
        logic irq;
        logic ss;
        logic cs;
        logic bad_crc;
        logic [31:0] buf_addr;
        logic [31:0] rdata;
        logic wr_pend;
        logic [7:0] wr_addr;
    } sids_st_t;

endpackage : sids_pkg

/* sids_core.sv */
// Split isochronous descriptor transfer-state logic with AHB-Lite registers
//
// Summary of operation
// - Finished split with interrupt bit set raises interrupt at next threshold.
// - Buffer address joins byte offset to page 0 or page 1 pointer.
// - Retiring leaves the page-select bit untouched.
// - Retire by clearing the active bit.
// - Progress mask records each complete split executed.
// - Error handshake from translator sets the error-response bit.
// - Overrun or underrun sets the buffer-error bit at status update.
// - Transmit underrun forces a bad CRC; overrun needs nothing more.
// - Babble on this descriptor's transaction sets the babble bit.
// - No valid device response sets the transaction-error bit.
// - Transaction-error bit is only set for IN transactions.
// - Host hold-off skipping a complete split sets missed-microframe bit.
// - In start phase, issue start split where start mask bit matches.
// - In complete phase, issue complete split where completion mask matches.
// - Low three frame index bits select the mask bit in use.
// - Completion mask, active and phase decide complete-split microframes.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sids_regs.svh"

module sids_core
    import sids_pkg::*;
#(
    parameter int FRAME_W = 14
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_uframe_start,
    input wire logic [FRAME_W-1:0] i_frame_index_counter,
    input wire logic i_dir_in,
    input wire logic i_result_valid,
    input wire logic i_resp_err,
    input wire logic i_overrun,
    input wire logic i_underrun,
    input wire logic i_babble,
    input wire logic i_no_response,
    input wire logic i_holdoff_miss,
    input wire logic i_split_finished,
    input wire logic i_irq_threshold,
    output logic o_start_split,
    output logic o_complete_split,
    output logic o_force_bad_crc,
    output logic o_irq,
    output logic o_active,
    output logic [31:0] o_buf_addr
);

    // ************************************************************
    // Helpers
    // ************************************************************

    function automatic logic bit_at(input logic [7:0] m, input logic [2:0] i);
        bit_at = m[i];
    endfunction : bit_at

    function automatic logic [31:0] join_addr(input logic psel,
                                              input logic [31:0] p0,
                                              input logic [31:0] p1);
        join_addr = psel ? {p1[31:12], p0[11:0]} : {p0[31:12], p0[11:0]};
    endfunction : join_addr

    function automatic logic [31:0] read_reg(input sids_st_t s,
                                             input logic [7:0] a);
        if (a == `SIDS_OFF_STATE) begin
            read_reg = s.state;
        end else if (a == `SIDS_OFF_PAGE0) begin
            read_reg = s.page0;
        end else if (a == `SIDS_OFF_PAGE1) begin
            read_reg = s.page1;
        end else if (a == `SIDS_OFF_MASKS) begin
            read_reg = {16'h0000, s.masks};
        end else begin
            read_reg = 32'h0000_0000;
        end
    endfunction : read_reg

    sids_st_t st_r;
    sids_st_t st_nxt;
    logic [2:0] uf_idx;

    assign uf_idx = i_frame_index_counter[2:0];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.ss = 1'b0;
        st_nxt.cs = 1'b0;
        st_nxt.bad_crc = 1'b0;
        st_nxt.irq = 1'b0;
        st_nxt.wr_pend = 1'b0;

        // Write data phase; hardware updates below win over it
        if (st_r.wr_pend) begin
            if (st_r.wr_addr == `SIDS_OFF_STATE) begin
                st_nxt.state = i_hwdata & `SIDS_STATE_WMASK;
            end else if (st_r.wr_addr == `SIDS_OFF_PAGE0) begin
                st_nxt.page0 = i_hwdata;
            end else if (st_r.wr_addr == `SIDS_OFF_PAGE1) begin
                st_nxt.page1 = i_hwdata;
            end else if (st_r.wr_addr == `SIDS_OFF_MASKS) begin
                st_nxt.masks = i_hwdata[15:0];
            end
        end

        // Address phase; read data is captured now, so no wait states
        if (i_hready && i_hsel && i_htrans[1]) begin
            st_nxt.wr_pend = i_hwrite;
            st_nxt.wr_addr = i_haddr[7:0];
            if (!i_hwrite) begin
                st_nxt.rdata = read_reg(st_r, i_haddr[7:0]);
            end
        end

        if (i_uframe_start && st_nxt.state[`SIDS_B_ACTIVE]) begin
            if (!st_nxt.state[`SIDS_B_PHASE] &&
                bit_at(st_nxt.masks[7:0], uf_idx)) begin
                st_nxt.ss = 1'b1;
                st_nxt.state[`SIDS_B_PHASE] = 1'b1;
                st_nxt.state[`SIDS_PROG_MSB:`SIDS_PROG_LSB] = 8'h00;
            end else if (st_nxt.state[`SIDS_B_PHASE] &&
                         bit_at(st_nxt.masks[15:8], uf_idx)) begin
                st_nxt.cs = 1'b1;
                st_nxt.state[`SIDS_PROG_LSB + uf_idx] = 1'b1;
            end
        end

        if (i_result_valid) begin
            if (i_resp_err) begin
                st_nxt.state[`SIDS_B_RESP_ERR] = 1'b1;
            end
            if (i_overrun || i_underrun) begin
                st_nxt.state[`SIDS_B_BUF_ERR] = 1'b1;
            end
            if (i_babble) begin
                st_nxt.state[`SIDS_B_BABBLE] = 1'b1;
            end
            if (i_no_response && i_dir_in) begin
                st_nxt.state[`SIDS_B_XACT_ERR] = 1'b1;
            end
            st_nxt.bad_crc = i_underrun && !i_dir_in;
        end

        if (i_holdoff_miss) begin
            st_nxt.state[`SIDS_B_MISSED] = 1'b1;
        end

        // Threshold first, so a completion in the same cycle is kept
        if (i_irq_threshold && st_r.irq_pend) begin
            st_nxt.irq = 1'b1;
            st_nxt.irq_pend = 1'b0;
        end

        if (i_split_finished && st_nxt.state[`SIDS_B_ACTIVE]) begin
            st_nxt.state[`SIDS_B_ACTIVE] = 1'b0;
            if (st_nxt.state[`SIDS_B_IOC]) begin
                st_nxt.irq_pend = 1'b1;
            end
        end

        st_nxt.buf_addr = join_addr(st_nxt.state[`SIDS_B_PSEL],
                                    st_nxt.page0, st_nxt.page1);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = st_r.rdata;
    assign o_start_split = st_r.ss;
    assign o_complete_split = st_r.cs;
    assign o_force_bad_crc = st_r.bad_crc;
    assign o_irq = st_r.irq;
    assign o_active = st_r.state[`SIDS_B_ACTIVE];
    assign o_buf_addr = st_r.buf_addr;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_irq_set;
        (i_split_finished && st_r.state[`SIDS_B_ACTIVE] &&
         st_r.state[`SIDS_B_IOC] && !st_r.wr_pend)
            ##1 i_irq_threshold |=> o_irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("completion interrupt not raised at threshold");

    property p_irq_cause;
        o_irq |-> $past(st_r.irq_pend) && $past(i_irq_threshold);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without pending completion");

    property p_page1;
        (st_r.state[`SIDS_B_PSEL] && !st_r.wr_pend)
            |=> o_buf_addr[31:12] == $past(st_r.page1[31:12]);
    endproperty
    a_page1: assert property (p_page1)
        else $error("page 1 pointer not used");

    property p_psel_kept;
        !st_r.wr_pend |=> st_r.state[`SIDS_B_PSEL] ==
                          $past(st_r.state[`SIDS_B_PSEL]);
    endproperty
    a_psel_kept: assert property (p_psel_kept)
        else $error("page select changed by hardware");

    property p_retire;
        (i_split_finished && !st_r.wr_pend)
            |=> !st_r.state[`SIDS_B_ACTIVE];
    endproperty
    a_retire: assert property (p_retire)
        else $error("descriptor not retired");

    property p_xact_out;
        (i_result_valid && !i_dir_in && !st_r.wr_pend &&
         !st_r.state[`SIDS_B_XACT_ERR])
            |=> !st_r.state[`SIDS_B_XACT_ERR];
    endproperty
    a_xact_out: assert property (p_xact_out)
        else $error("transaction error set on OUT");

    property p_bad_crc;
        o_force_bad_crc |-> $past(i_result_valid && i_underrun && !i_dir_in);
    endproperty
    a_bad_crc: assert property (p_bad_crc)
        else $error("bad CRC without transmit underrun");

    property p_ss_phase;
        o_start_split |-> st_r.state[`SIDS_B_PHASE] &&
            st_r.state[`SIDS_PROG_MSB:`SIDS_PROG_LSB] == 8'h00 &&
            $past(i_uframe_start);
    endproperty
    a_ss_phase: assert property (p_ss_phase)
        else $error("start split left wrong phase or progress");

    property p_cs_match;
        (o_complete_split && !$past(st_r.wr_pend)) |->
            $past(st_r.state[`SIDS_B_PHASE]) &&
            $past(st_r.masks[8 + i_frame_index_counter[2:0]]) &&
            st_r.state[`SIDS_PROG_LSB + $past(i_frame_index_counter[2:0])];
    endproperty
    a_cs_match: assert property (p_cs_match)
        else $error("complete split without phase or mask match");

    property p_no_ioc;
        (i_split_finished && st_r.state[`SIDS_B_ACTIVE] &&
         !st_r.state[`SIDS_B_IOC] && !st_r.irq_pend && !st_r.wr_pend)
            |=> !st_r.irq_pend;
    endproperty
    a_no_ioc: assert property (p_no_ioc)
        else $error("interrupt pended without interrupt bit");

    property p_resp_err;
        (i_result_valid && i_resp_err) |=> st_r.state[`SIDS_B_RESP_ERR];
    endproperty
    a_resp_err: assert property (p_resp_err)
        else $error("error handshake not recorded");

    property p_buf_err;
        (i_result_valid && (i_overrun || i_underrun))
            |=> st_r.state[`SIDS_B_BUF_ERR];
    endproperty
    a_buf_err: assert property (p_buf_err)
        else $error("overrun or underrun not recorded");

    property p_babble;
        (i_result_valid && i_babble) |=> st_r.state[`SIDS_B_BABBLE];
    endproperty
    a_babble: assert property (p_babble)
        else $error("babble not recorded");

    property p_xact_in;
        (i_result_valid && i_no_response && i_dir_in)
            |=> st_r.state[`SIDS_B_XACT_ERR];
    endproperty
    a_xact_in: assert property (p_xact_in)
        else $error("missing response on IN not recorded");

    property p_missed;
        i_holdoff_miss |=> st_r.state[`SIDS_B_MISSED];
    endproperty
    a_missed: assert property (p_missed)
        else $error("missed microframe not recorded");

    property p_ss_match;
        (i_uframe_start && !st_r.wr_pend && st_r.state[`SIDS_B_ACTIVE] &&
         !st_r.state[`SIDS_B_PHASE] &&
         st_r.masks[i_frame_index_counter[2:0]]) |=> o_start_split;
    endproperty
    a_ss_match: assert property (p_ss_match)
        else $error("start split not issued on mask match");

    property p_idle_quiet;
        (i_uframe_start && !st_r.wr_pend && !st_r.state[`SIDS_B_ACTIVE])
            |=> !o_start_split && !o_complete_split;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("split issued while descriptor inactive");

endmodule : sids_core

/* sids_tt_model.sv */
// Translator model that returns one transaction result per request, except a hold-off miss for kind 5
`timescale 1ns/1ps

module sids_tt_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [2:0] i_kind,
    output logic o_valid = 1'b0,
    output logic [4:0] o_flags = 5'h0a,
    output logic o_miss = 1'b0
);
    // ****************************************
    // Result generation
    // ****************************************
    // one result a request, a miss for kind 5
    always @(posedge i_clk) begin
        o_valid <= i_go && (i_kind != 3'h5);
        o_miss <= i_go && (i_kind == 3'h5);
        // Flags toggle outside a result, so stale levels are never trusted
        if (i_go && i_kind != 3'h5) begin
            o_flags <= 5'h01 << ((i_kind == 3'h6) ? 3'h4 : i_kind);
        end else begin
            o_flags <= ~o_flags;
        end
    end
endmodule : sids_tt_model

/* tb_top.sv */
// Self-checking bench of the descriptor state block
`timescale 1ns/1ps
`include "sids_regs.svh"

module tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, go = 0, dir = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [2:0] ev = 0, kind = 0;
    logic [13:0] fidx = 0;
    logic [7:0] expv [0:6] = '{8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00};
    wire logic hready, hresp, ssp, csp, crc, irq, act, valid, miss;
    wire logic [31:0] hrdata, baddr;
    wire logic [4:0] flags;
    int bad_count = 0, comparisons = 0, n_ss = 0, n_cs = 0, n_irq = 0, n_crc = 0;
    int s;

    always #2 clk = ~clk;
    // Pulse counters keep checks free of exact sampling instants
    always @(posedge clk) begin
        if (ssp === 1'b1) n_ss++;
        if (csp === 1'b1) n_cs++;
        if (irq === 1'b1) n_irq++;
        if (crc === 1'b1) n_crc++;
    end

    sids_core #(.FRAME_W(14)) u_dut (.i_clk(clk), .i_reset(rst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_uframe_start(ev[0]),
        .i_frame_index_counter(fidx), .i_dir_in(dir),
        .i_result_valid(valid), .i_resp_err(flags[0]),
        .i_overrun(flags[1]), .i_underrun(flags[2]),
        .i_babble(flags[3]), .i_no_response(flags[4]),
        .i_holdoff_miss(miss), .i_split_finished(ev[1]),
        .i_irq_threshold(ev[2]), .o_start_split(ssp),
        .o_complete_split(csp), .o_force_bad_crc(crc), .o_irq(irq),
        .o_active(act), .o_buf_addr(baddr));
    sids_tt_model u_tt (.i_clk(clk), .i_go(go), .i_kind(kind),
        .o_valid(valid), .o_flags(flags), .o_miss(miss));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic wrap_up;
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        // Idle cycle keeps a following read clear of the stale window
        if (w) @(posedge clk);
    endtask : bus

    task automatic pulse(input logic [2:0] e);
        ev <= e;
        @(posedge clk);
        ev <= 3'h0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk({29'h0, hready, hresp, act}, 32'h4);
        bus(0, `SIDS_OFF_STATE, 0);
        chk(rd, `SIDS_RST_WORD);
        bus(1, 8'h40, 32'hdead_beef);
        bus(0, 8'h40, 0);
        chk(rd, 0);
    endtask : t_reset

    task automatic t_mask;
        bus(1, `SIDS_OFF_STATE, 32'hffff_ffff);
        bus(0, `SIDS_OFF_STATE, 0);
        chk(rd, 32'hc3ff_fffe);
        chk(act, 1);
        bus(1, `SIDS_OFF_STATE, 0);
        chk(act, 0);
    endtask : t_mask

    task automatic t_addr;
        bus(1, `SIDS_OFF_PAGE0, 32'h1234_5abc);
        bus(1, `SIDS_OFF_PAGE1, 32'h9876_5fff);
        chk(baddr, 32'h1234_5abc);
        bus(1, `SIDS_OFF_STATE, 32'h4000_0000);
        chk(baddr, 32'h9876_5abc);
    endtask : t_addr

    task automatic t_split;
        bus(1, `SIDS_OFF_MASKS, 32'h0000_6008);
        bus(1, `SIDS_OFF_STATE, 32'hc3ff_ff80);
        s = n_ss;
        fidx <= 14'h0004;
        pulse(3'h1);
        chk(n_ss - s, 0);
        fidx <= 14'h3ffb;
        pulse(3'h1);
        chk(n_ss - s, 1);
        bus(0, `SIDS_OFF_STATE, 0);
        chk(rd, 32'hc3ff_0082);
        s = n_cs;
        fidx <= 14'h0005;
        pulse(3'h1);
        chk(n_cs - s, 1);
        bus(0, `SIDS_OFF_STATE, 0);
        chk(rd, 32'hc3ff_2082);
        s = n_irq;
        pulse(3'h4);
        chk(n_irq - s, 0);
        pulse(3'h2);
        bus(0, `SIDS_OFF_STATE, 0);
        chk(rd, 32'hc3ff_2002);
        pulse(3'h4);
        chk(n_irq - s, 1);
        s = n_cs;
        pulse(3'h1);
        chk(n_cs - s, 0);
    endtask : t_split

    task automatic t_noioc;
        bus(1, `SIDS_OFF_STATE, 32'h0000_0080);
        s = n_irq;
        pulse(3'h2);
        pulse(3'h4);
        chk(n_irq - s, 0);
    endtask : t_noioc

    task automatic t_irq_next;
        bus(1, `SIDS_OFF_STATE, 32'h8000_0080);
        s = n_irq;
        ev <= 3'h2;
        @(posedge clk);
        ev <= 3'h4;
        @(posedge clk);
        ev <= 3'h0;
        repeat (2) @(posedge clk);
        chk(n_irq - s, 1);
        chk(act, 0);
    endtask : t_irq_next

    task automatic t_err;
        for (int k = 0; k < 7; k++) begin
            bus(1, `SIDS_OFF_STATE, 32'h0000_0080);
            dir <= (k == 4);
            kind <= k[2:0];
            go <= 1'b1;
            s = n_crc;
            @(posedge clk);
            go <= 1'b0;
            repeat (3) @(posedge clk);
            bus(0, `SIDS_OFF_STATE, 0);
            chk(rd, {24'h0, 8'h80 | expv[k]});
            chk(n_crc - s, (k == 2));
        end
    endtask : t_err

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        hsel <= 1'b1;
        @(posedge clk);
        t_reset;
        t_mask;
        t_addr;
        t_split;
        t_noioc;
        t_irq_next;
        t_err;
        wrap_up;
    end

    // Whole run needs about 150 cycles
    initial begin
        #20000;
        bad_count++;
        wrap_up;
    end
endmodule : tb_top
